/* pkg/hie_pkg.sv */
/*
 * constants shared by the channel 3 host interrupt enable block: register
 * offsets, bit positions, reset values and request indices.
 * assumes an 8-bit local register port and one 100 MHz clock.
 */

package hie_pkg;

	// ****************************************************************
	// register port
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h3;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int BIT_IRQ10  = 6;
	localparam int BIT_IRQ9   = 5;
	localparam int BIT_IRQ6   = 4;
	localparam int BIT_DIRECT = 0;

	// request order used on the internal carrier and by the enable helpers
	localparam int REQ_W     = 3;
	localparam int REQ_IRQ6  = 0;
	localparam int REQ_IRQ9  = 1;
	localparam int REQ_IRQ10 = 2;

	localparam int ST_W       = 3;
	localparam int ST_OBF_SET = 0;
	localparam int ST_AUTO_CL = 1;
	localparam int ST_LPC_RST = 2;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [REQ_W-1:0] ENABLE_RST = 3'h0;
	localparam logic             DIRECT_RST = 1'b0;
	localparam logic [ST_W-1:0]  STATUS_RST = 3'h0;
	localparam logic [ST_W-1:0]  MASK_RST   = 3'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// enable bits out of a register byte, in request order
	function automatic logic [REQ_W-1:0] hie_pick_en(input logic [DATA_W-1:0] b);
		hie_pick_en = {b[BIT_IRQ10], b[BIT_IRQ9], b[BIT_IRQ6]};
	endfunction

	// request-order enables placed back at their byte positions
	function automatic logic [DATA_W-1:0] hie_place_en(input logic [REQ_W-1:0] e);
		logic [DATA_W-1:0] b;
		b = 8'h00;
		b[BIT_IRQ10] = e[REQ_IRQ10];
		b[BIT_IRQ9]  = e[REQ_IRQ9];
		b[BIT_IRQ6]  = e[REQ_IRQ6];
		hie_place_en = b;
	endfunction

endpackage

/* pkg/hie_req_if.sv */
/*
 * carrier between the enable register logic and the request generator.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface hie_req_if;
	logic [hie_pkg::REQ_W-1:0] en;
	logic                      direct;
	logic                      obf;
	logic [hie_pkg::REQ_W-1:0] other;
	logic [hie_pkg::REQ_W-1:0] req;

	modport ctl (output en, output direct, output obf, output other, input req);
	modport gen (input en, input direct, input obf, input other, output req);
endinterface

`default_nettype wire

/* hw/hie_req_gen.sv */
/*
 * turns channel 3 enables, mode and output-full flag into registered host
 * interrupt request levels, merged with requests of the other channels.
 * assumes a synchronous active-high reset on the shared clock.
 */
`timescale 1ns/1ps
`default_nettype none

module hie_req_gen (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// carrier
	hie_req_if.gen    rq
);
	import hie_pkg::*;

	logic [REQ_W-1:0] req_r;
	logic [REQ_W-1:0] req_nxt;
	logic [REQ_W-1:0] ch3_req;

	// ****************************************************************
	// request decision
	// ****************************************************************
	always_comb begin
		if (rq.direct) begin
			ch3_req = rq.en;
		end else begin
			ch3_req = rq.en & {REQ_W{rq.obf}};
		end
		req_nxt = ch3_req | rq.other;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			req_r <= 3'h0;
		end else begin
			req_r <= req_nxt;
		end
	end

	assign rq.req = req_r;

endmodule

`default_nettype wire

/* hw/hie_ch3_top.sv */
/*
 * channel 3 host interrupt enable block: enable bits for host irq 10, 9
 * and 6, their read-then-write set guard, automatic clearing, a small
 * event status/mask unit and the registered host request lines.
 * register map, one byte each:
 *   0 enable: bit 6 irq 10, bit 5 irq 9, bit 4 irq 6
 *   1 ctrl:   bit 0 direct request mode
 *   2 status: bit 0 flag rose, bit 1 live enables auto-cleared,
 *             bit 2 lpc reset seen; a read clears it
 *   3 mask:   same layout as status
 * assumes a local register port with read data one cycle after the read
 * strobe, synchronous inputs, and lpc resets given as synchronous levels.
 * the host never reaches these registers; only the lpc resets and the
 * request lines cross to its side.
 */
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module hie_ch3_top (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       reset,
	// local register port
	input  wire logic [hie_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [hie_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [hie_pkg::DATA_W-1:0] reg_rdata,
	// channel 3 state
	input  wire logic                       ch3_output_full_flag,
	// lpc resets
	input  wire logic                       lpc_hw_reset,
	input  wire logic                       lpc_sw_reset,
	// requests of the other channels
	input  wire logic                       other_irq6_req,
	input  wire logic                       other_irq9_req,
	input  wire logic                       other_irq10_req,
	// host request lines
	output logic                            host_irq_line_6,
	output logic                            host_irq_line_9,
	output logic                            host_irq_line_10,
	// local interrupt
	output logic                            irq
);
	import hie_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// one register hit: strobe high and the address on the offset
	function automatic logic hie_hit(
		input              strobe,
		input [ADDR_W-1:0] addr,
		input [ADDR_W-1:0] ofs
	);
		hie_hit = strobe && (addr == ofs);
	endfunction

	// a status-layout value widened to a register byte
	function automatic logic [DATA_W-1:0] hie_st_byte(
		input [ST_W-1:0] s
	);
		hie_st_byte = {{(DATA_W-ST_W){1'b0}}, s};
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	logic [REQ_W-1:0]  en_r;
	logic [REQ_W-1:0]  en_nxt;
	logic [REQ_W-1:0]  armed_r;
	logic [REQ_W-1:0]  armed_nxt;
	logic              direct_r;
	logic              obf_prev_r;
	logic [ST_W-1:0]   status_r;
	logic [ST_W-1:0]   status_nxt;
	logic [ST_W-1:0]   status_set;
	logic [ST_W-1:0]   mask_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              irq_r;
	logic [DATA_W-1:0] en_byte;
	logic [DATA_W-1:0] ctrl_byte;
	logic [DATA_W-1:0] status_byte;
	logic [DATA_W-1:0] mask_byte;

	// ****************************************************************
	// decode
	// ****************************************************************
	logic             wr_enable;
	logic             wr_ctrl;
	logic             wr_mask;
	logic             rd_enable;
	logic             rd_status;
	logic             obf_rise;
	logic             obf_fall;
	logic             lpc_clr;
	logic             auto_clr;
	logic [REQ_W-1:0] wr_bits;
	logic             ev_obf_set;
	logic             ev_auto_cl;
	logic             ev_lpc_rst;

	assign wr_enable = hie_hit(reg_wr, reg_addr, OFS_ENABLE);
	assign wr_ctrl   = hie_hit(reg_wr, reg_addr, OFS_CTRL);
	assign wr_mask   = hie_hit(reg_wr, reg_addr, OFS_MASK);
	assign rd_enable = hie_hit(reg_rd, reg_addr, OFS_ENABLE);
	assign rd_status = hie_hit(reg_rd, reg_addr, OFS_STATUS);
	assign wr_bits   = hie_pick_en(reg_wdata);

	// the flag is taken as synchronous, so one stage of history suffices
	assign obf_rise = ch3_output_full_flag && !obf_prev_r;
	assign obf_fall = !ch3_output_full_flag && obf_prev_r;
	assign lpc_clr  = lpc_hw_reset || lpc_sw_reset;
	assign auto_clr = !direct_r && obf_fall;

	// history resets low like the idle flag, so no false rise follows reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			obf_prev_r <= 1'b0;
		end else begin
			obf_prev_r <= ch3_output_full_flag;
		end
	end

	// ****************************************************************
	// enable bits
	// ****************************************************************
	// hardware clears outrank a software write in the same cycle, so a
	// stale write can never re-arm a request the channel just retired;
	// a written 0 lands armed or not, so software can always withdraw
	always_comb begin
		en_nxt = en_r;
		if (lpc_clr) begin
			en_nxt = ENABLE_RST;
		end else if (auto_clr) begin
			en_nxt = ENABLE_RST;
		end else if (wr_enable) begin
			for (int i = 0; i < REQ_W; i++) begin
				if (!wr_bits[i]) begin
					en_nxt[i] = 1'b0;
				end else if (armed_r[i]) begin
					en_nxt[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			en_r <= ENABLE_RST;
		end else begin
			en_r <= en_nxt;
		end
	end

	// ****************************************************************
	// read-then-write guard
	// ****************************************************************
	// a bit is armed by a read that returns it as 0; any write to the
	// enable register consumes the arming, used or not
	// arming is per bit: a read that finds a bit set leaves it unarmed
	always_comb begin
		armed_nxt = armed_r;
		if (lpc_clr || wr_enable) begin
			armed_nxt = {REQ_W{1'b0}};
		end else if (rd_enable) begin
			armed_nxt = armed_r | ~en_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			armed_r <= {REQ_W{1'b0}};
		end else begin
			armed_r <= armed_nxt;
		end
	end

	// ****************************************************************
	// control
	// ****************************************************************
	// lpc resets leave the mode alone; only the system reset or a ctrl write of 0 clears it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			direct_r <= DIRECT_RST;
		end else if (wr_ctrl) begin
			direct_r <= reg_wdata[BIT_DIRECT];
		end
	end

	// ****************************************************************
	// status events
	// ****************************************************************
	// an auto clear only counts when it retires a live enable
	assign ev_obf_set = obf_rise;
	assign ev_auto_cl = auto_clr && (en_r != ENABLE_RST);
	assign ev_lpc_rst = lpc_clr;

	// ****************************************************************
	// event status and mask
	// ****************************************************************
	// each status bit is sticky until software reads the register
	always_comb begin
		status_set             = {ST_W{1'b0}};
		status_set[ST_OBF_SET] = ev_obf_set;
		status_set[ST_AUTO_CL] = ev_auto_cl;
		status_set[ST_LPC_RST] = ev_lpc_rst;
		// a new event in the read cycle survives the read-clear
		status_nxt = (rd_status ? {ST_W{1'b0}} : status_r) | status_set;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			status_r <= STATUS_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mask_r <= MASK_RST;
		end else if (wr_mask) begin
			mask_r <= reg_wdata[ST_W-1:0];
		end
	end

	// ****************************************************************
	// local interrupt
	// ****************************************************************
	// one cycle behind the status bits; keeps the output a plain flop
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(status_r & mask_r);
		end
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	// register images as software sees them
	always_comb begin
		ctrl_byte             = RDATA_RST;
		ctrl_byte[BIT_DIRECT] = direct_r;
	end

	assign en_byte     = hie_place_en(en_r);
	assign status_byte = hie_st_byte(status_r);
	assign mask_byte   = hie_st_byte(mask_r);

	// data stand only in the cycle after the strobe; unmapped reads give 0
	always_comb begin
		rdata_nxt = RDATA_RST;
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_ENABLE: rdata_nxt = en_byte;
				OFS_CTRL:   rdata_nxt = ctrl_byte;
				OFS_STATUS: rdata_nxt = status_byte;
				OFS_MASK:   rdata_nxt = mask_byte;
				default:    rdata_nxt = RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_r <= RDATA_RST;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ****************************************************************
	// request generation
	// ****************************************************************
	hie_req_if rq ();

	assign rq.en               = en_r;
	assign rq.direct           = direct_r;
	assign rq.obf              = ch3_output_full_flag;
	// one driver for the whole vector, packed in request order 10, 9, 6
	assign rq.other            = {other_irq10_req, other_irq9_req, other_irq6_req};

	hie_req_gen u_req_gen (
		.ref_clk (ref_clk),
		.reset   (reset),
		.rq      (rq.gen)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign reg_rdata        = rdata_r;
	assign host_irq_line_6  = rq.req[REQ_IRQ6];
	assign host_irq_line_9  = rq.req[REQ_IRQ9];
	assign host_irq_line_10 = rq.req[REQ_IRQ10];
	assign irq              = irq_r;

endmodule

`default_nettype wire

/* tb/hie_ch3_top_sva.sv */
/* port checker for hie_ch3_top.
   assumes the bind below reaches every instance of the top. */
`timescale 1ns/1ps
`default_nettype none
module hie_ch3_chk (
	// clock and reset
	input wire logic			ref_clk,
	input wire logic			reset,
	// register port
	input wire logic [hie_pkg::ADDR_W-1:0]	reg_addr,
	input wire logic [hie_pkg::DATA_W-1:0]	reg_wdata,
	input wire logic			reg_wr,
	input wire logic			reg_rd,
	input wire logic [hie_pkg::DATA_W-1:0]	reg_rdata,
	// lpc resets and other channels
	input wire logic			lpc_hw_reset,
	input wire logic			lpc_sw_reset,
	input wire logic			other_irq6_req,
	input wire logic			other_irq9_req,
	input wire logic			other_irq10_req,
	// outputs
	input wire logic			host_irq_line_6,
	input wire logic			host_irq_line_9,
	input wire logic			host_irq_line_10,
	input wire logic			irq
);
	import hie_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ********
	// sequences and properties
	// ********
	// a set needs a fresh read, so nothing can revive the bit within one cycle
	sequence s_lpc;
		(lpc_hw_reset || lpc_sw_reset) ##1 !other_irq9_req;
	endsequence
	sequence s_wr0;
		reg_wr && reg_addr == OFS_ENABLE && !reg_wdata[BIT_IRQ6] && !other_irq6_req
		##1 !other_irq6_req;
	endsequence
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == RDATA_RST;
	endproperty
	property p_en_rsvd;
		reg_rd && reg_addr == OFS_ENABLE |=> (reg_rdata & 8'h8f) == 8'h00;
	endproperty
	property p_unmapped;
		reg_rd && reg_addr > OFS_MASK |=> reg_rdata == 8'h00;
	endproperty
	property p_or6;
		other_irq6_req |=> host_irq_line_6;
	endproperty
	property p_or9;
		other_irq9_req |=> host_irq_line_9;
	endproperty
	property p_or10;
		other_irq10_req |=> host_irq_line_10;
	endproperty
	property p_lpc;
		s_lpc |=> !host_irq_line_9;
	endproperty
	property p_wr0;
		s_wr0 |=> !host_irq_line_6;
	endproperty
	property p_rst_out;
		$fell(reset) |-> !(host_irq_line_6 || host_irq_line_9 || host_irq_line_10 || irq);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	a_en_rsvd: assert property (p_en_rsvd) else $error("enable spare bits");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	a_or6: assert property (p_or6) else $error("line 6 merge");
	a_or9: assert property (p_or9) else $error("line 9 merge");
	a_or10: assert property (p_or10) else $error("line 10 merge");
	a_lpc: assert property (p_lpc) else $error("lpc reset kept line 9");
	a_wr0: assert property (p_wr0) else $error("written 0 kept line 6");
	a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
endmodule
bind hie_ch3_top hie_ch3_chk u_chk (.ref_clk(ref_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .lpc_hw_reset(lpc_hw_reset), .lpc_sw_reset(lpc_sw_reset),
	.other_irq6_req(other_irq6_req), .other_irq9_req(other_irq9_req),
	.other_irq10_req(other_irq10_req), .host_irq_line_6(host_irq_line_6),
	.host_irq_line_9(host_irq_line_9), .host_irq_line_10(host_irq_line_10), .irq(irq));
`default_nettype wire

/* tb/hie_host_model.sv */
/* host side model: records request lines, issues lpc resets on command.
   assumes the bench pulses rst_cmd for one cycle. */
`timescale 1ns/1ps
`default_nettype none
module hie_host_model (
	// clock and reset
	input wire logic	ref_clk,
	input wire logic	reset,
	// request lines
	input wire logic [2:0]	lines,
	// commands and results
	input wire logic [1:0]	rst_cmd,
	output logic		lpc_hw_reset,
	output logic		lpc_sw_reset,
	output logic [2:0]	seen
);
	// host never reaches the enable bits, only resets and lines
	always_ff @(posedge ref_clk) begin
		lpc_hw_reset <= !reset && rst_cmd[0];
		lpc_sw_reset <= !reset && rst_cmd[1];
	end
	always_ff @(posedge ref_clk) begin
		seen <= reset ? 3'h0 : seen | lines;
	end
endmodule
`default_nettype wire

/* tb/tb_hie_ch3_top.sv */
/* self-checking bench for hie_ch3_top.
   assumes the checker is bound and the host model drives lpc resets. */
`timescale 1ns/1ps
`default_nettype none
module tb_hie_ch3_top;
	import hie_pkg::*;
	logic			ref_clk = 1'b0;
	logic			reset = 1'b1;
	logic [ADDR_W-1:0]	reg_addr = 4'h0;
	logic [DATA_W-1:0]	reg_wdata = 8'h00;
	logic			reg_wr = 1'b0;
	logic			reg_rd = 1'b0;
	logic			flag = 1'b0;
	logic [2:0]		other = 3'h0;
	logic [1:0]		rst_cmd = 2'h0;
	logic [DATA_W-1:0]	v;
	wire logic [DATA_W-1:0]	reg_rdata;
	wire logic [2:0]	lines;
	wire logic [2:0]	seen;
	wire logic		hw_rst;
	wire logic		sw_rst;
	wire logic		irq;
	int			num_errors = 0;
	int			comparisons = 0;
	// mode, enables {10,9,6}, flag, expected lines
	logic [7:0] rows [8] = '{8'h2a, 8'h19, 8'h70, 8'ha2, 8'h91, 8'hc4, 8'hff, 8'h4c};

	always #5 ref_clk = ~ref_clk;

	hie_ch3_top uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ch3_output_full_flag(flag), .lpc_hw_reset(hw_rst), .lpc_sw_reset(sw_rst),
		.other_irq6_req(other[0]), .other_irq9_req(other[1]), .other_irq10_req(other[2]),
		.host_irq_line_6(lines[0]), .host_irq_line_9(lines[1]),
		.host_irq_line_10(lines[2]), .irq(irq));
	hie_host_model u_host (.ref_clk(ref_clk), .reset(reset), .lines(lines),
		.rst_cmd(rst_cmd), .lpc_hw_reset(hw_rst), .lpc_sw_reset(sw_rst), .seen(seen));

	// ********
	// tasks
	// ********
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	// strobes drop for a cycle between calls so no signal is set twice at one edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		rd(OFS_ENABLE);
		chk("enable at reset", 8'h00, v);
		rd(4'hf);
		chk("unmapped", 8'h00, v);
		wr(OFS_ENABLE, 8'h00);
		wr(OFS_ENABLE, 8'h70);
		rd(OFS_ENABLE);
		chk("set unread", 8'h00, v);
		$display("test reset and guard done");
		foreach (rows[i]) begin
			wr(OFS_ENABLE, 8'h00);
			@(posedge ref_clk);
			flag <= rows[i][3];
			wr(OFS_CTRL, {7'h0, rows[i][7]});
			rd(OFS_ENABLE);
			wr(OFS_ENABLE, {1'b0, rows[i][6:4], 4'h0});
			rd(OFS_ENABLE);
			chk("readback", {1'b0, rows[i][6:4], 4'h0}, v);
			wt(2);
			chk("lines", {5'h0, rows[i][2:0]}, {5'h0, lines});
		end
		$display("test table done");
		// write of 0, then hardware and software lpc reset
		for (int k = 0; k < 3; k++) begin
			wr(OFS_CTRL, 8'h01);
			wr(OFS_ENABLE, 8'h00);
			rd(OFS_ENABLE);
			wr(OFS_ENABLE, 8'h70);
			if (k == 0) begin
				wr(OFS_ENABLE, 8'h00);
			end else begin
				@(posedge ref_clk);
				rst_cmd <= k[1:0];
				@(posedge ref_clk);
				rst_cmd <= 2'h0;
			end
			wt(3);
			rd(OFS_ENABLE);
			chk("cleared", 8'h00, v);
			chk("lines off", 8'h00, {5'h0, lines});
			rd(OFS_STATUS);
			chk("lpc event", (k != 0) ? 8'h04 : 8'h00, v & 8'h04);
		end
		$display("test clear done");
		wr(OFS_CTRL, 8'h00);
		@(posedge ref_clk);
		flag <= 1'b1;
		rd(OFS_ENABLE);
		wr(OFS_ENABLE, 8'h30);
		@(posedge ref_clk);
		flag <= 1'b0;
		wt(2);
		rd(OFS_ENABLE);
		chk("auto clear", 8'h00, v);
		rd(OFS_STATUS);
		chk("auto clear event", 8'h02, v & 8'h02);
		$display("test auto clear done");
		// mid-run reset with every line up; the host record clears with it
		wr(OFS_CTRL, 8'h01);
		rd(OFS_ENABLE);
		wr(OFS_ENABLE, 8'h70);
		wt(2);
		chk("lines up", 8'h07, {5'h0, lines});
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		rd(OFS_ENABLE);
		chk("enable after reset", 8'h00, v);
		rd(OFS_CTRL);
		chk("mode after reset", 8'h00, v);
		chk("lines after reset", 8'h00, {5'h0, lines});
		chk("host after reset", 8'h00, {5'h0, seen});
		$display("test mid-run reset done");
		@(posedge ref_clk);
		other <= 3'h7;
		wt(2);
		chk("merged", 8'h07, {5'h0, lines});
		chk("host saw", 8'h07, {5'h0, seen});
		@(posedge ref_clk);
		other <= 3'h0;
		$display("test merge done");
		wr(OFS_MASK, 8'h01);
		rd(OFS_MASK);
		chk("mask", 8'h01, v);
		rd(OFS_STATUS);
		@(posedge ref_clk);
		flag <= 1'b1;
		wt(3);
		chk("irq up", 8'h01, {7'h0, irq});
		rd(OFS_STATUS);
		chk("status", 8'h01, v & 8'h01);
		wt(2);
		chk("irq read clear", 8'h00, {7'h0, irq});
		wr(OFS_MASK, 8'h00);
		@(posedge ref_clk);
		flag <= 1'b0;
		@(posedge ref_clk);
		flag <= 1'b1;
		wt(3);
		chk("irq masked", 8'h00, {7'h0, irq});
		$display("test irq done");
		summarize();
	end
endmodule
`default_nettype wire
